// ---- mpr_base_field.sv ----
// One writable base-address field with its read-only zero low bits
`timescale 1ns/100ps
`default_nettype none
`include "mpr_defs.svh"
module mpr_base_field #(
  parameter int W = 5
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         wr_en,
  input  wire logic [31:0]  wdata,
  output logic      [31:0]  value
);
  logic [W-1:0] fld_reg;
  logic [W-1:0] fld_next;

  always_comb begin
    fld_next = fld_reg;
    if (wr_en) begin
      fld_next = wdata[`MPR_FLD_LSB +: W];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fld_reg <= '0;
    end else begin
      fld_reg <= fld_next;
    end
  end

  // Upper reserved bits and low 11 bits read zero
  assign value = {{(32 - W - `MPR_FLD_LSB){1'b0}}, fld_reg, {`MPR_FLD_LSB{1'b0}}};
endmodule
`default_nettype wire

// ---- mpr_decode.sv ----
// Address decode of the register offsets
`timescale 1ns/100ps
`default_nettype none
`include "mpr_defs.svh"
module mpr_decode (
  input  wire logic [11:0]      paddr,
  output mpr_pkg::mpr_sel_t     sel
);
  always_comb begin
    unique case (paddr)
      `MPR_OFS_KERNEL_PROG:     sel = mpr_pkg::MPR_SEL_KPB;
      `MPR_OFS_USER_DATA:       sel = mpr_pkg::MPR_SEL_UDB;
      `MPR_OFS_USER_PROG:       sel = mpr_pkg::MPR_SEL_UPB;
      `MPR_OFS_DATA_RAM_SIZE:   sel = mpr_pkg::MPR_SEL_DRS;
      `MPR_OFS_FLASH_USER_PROG: sel = mpr_pkg::MPR_SEL_FUP;
      `MPR_OFS_FLASH_SIZE:      sel = mpr_pkg::MPR_SEL_PFS;
      `MPR_OFS_BOOT_SIZE:       sel = mpr_pkg::MPR_SEL_BFS;
      default:                  sel = mpr_pkg::MPR_SEL_NONE;
    endcase
  end
endmodule
`default_nettype wire

// ---- mpr_defs.svh ----
// Register offsets, field positions, reset values and sizes of the partition registers
`ifndef MPR_DEFS_SVH
`define MPR_DEFS_SVH
`define MPR_OFS_KERNEL_PROG     12'h000
`define MPR_OFS_USER_DATA       12'h004
`define MPR_OFS_USER_PROG       12'h008
`define MPR_OFS_DATA_RAM_SIZE   12'h00C
`define MPR_OFS_FLASH_USER_PROG 12'h010
`define MPR_OFS_FLASH_SIZE      12'h014
`define MPR_OFS_BOOT_SIZE       12'h018
`define MPR_RAM_FLD_MSB         15
`define MPR_FLASH_FLD_MSB       19
`define MPR_FLD_LSB             11
`define MPR_RAM_FLD_RESET       5'h0
`define MPR_FLASH_FLD_RESET     9'h000
`define MPR_DATA_RAM_SIZE       32'h0000_8000
`define MPR_FLASH_SIZE          32'h0008_0000
`define MPR_BOOT_SIZE           32'h0000_3000
`define MPR_USER_RAM_PHYS       32'hBF00_0000
`define MPR_USER_FLASH_PHYS     32'hBD00_0000
`endif

// ---- mpr_pkg.sv ----
// Types shared by the partition register bank
package mpr_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mpr_apb_req_t;

  typedef struct packed {
    logic [31:0] ram_kernel_program_base;
    logic [31:0] ram_user_data_base;
    logic [31:0] ram_user_program_base;
    logic [31:0] flash_user_program_base;
    logic [31:0] user_ram_phys_start;
    logic [31:0] user_flash_phys_start;
  } mpr_map_t;

  typedef enum logic [2:0] {
    MPR_SEL_KPB, MPR_SEL_UDB, MPR_SEL_UPB, MPR_SEL_DRS, MPR_SEL_FUP, MPR_SEL_PFS, MPR_SEL_BFS, MPR_SEL_NONE
  } mpr_sel_t;
endpackage

// ---- mpr_regs.sv ----
// APB register bank that places user and kernel memory partitions
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mpr_defs.svh"
module mpr_regs #(
  parameter logic [31:0] DATA_RAM_SIZE = `MPR_DATA_RAM_SIZE,
  parameter logic [31:0] FLASH_SIZE    = `MPR_FLASH_SIZE
) (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire mpr_pkg::mpr_apb_req_t apb_req,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output mpr_pkg::mpr_map_t          map
);
  mpr_pkg::mpr_sel_t sel;
  logic              wr;
  logic              rd;
  logic [31:0]       kpb;
  logic [31:0]       udb;
  logic [31:0]       upb;
  logic [31:0]       fup;
  logic [31:0]       prdata_reg;
  logic [31:0]       prdata_next;
  logic              pslverr_reg;
  logic              pslverr_next;

  // Strobe of one register: a write access cycle whose offset decodes to it
  function automatic logic reg_hit(input logic              strobe,
                                   input mpr_pkg::mpr_sel_t cur,
                                   input mpr_pkg::mpr_sel_t want);
    return strobe && (cur == want);
  endfunction

  mpr_decode u_dec (
    .paddr (apb_req.paddr),
    .sel   (sel)
  );

  // Zero-wait slave: write and read data take effect in the access cycle
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign pready = 1'b1;

  mpr_base_field #(.W(`MPR_RAM_FLD_MSB - `MPR_FLD_LSB + 1)) u_kpb (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .wr_en   (reg_hit(wr, sel, mpr_pkg::MPR_SEL_KPB)),
    .wdata   (apb_req.pwdata),
    .value   (kpb)
  );

  mpr_base_field #(.W(`MPR_RAM_FLD_MSB - `MPR_FLD_LSB + 1)) u_udb (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .wr_en   (reg_hit(wr, sel, mpr_pkg::MPR_SEL_UDB)),
    .wdata   (apb_req.pwdata),
    .value   (udb)
  );

  mpr_base_field #(.W(`MPR_RAM_FLD_MSB - `MPR_FLD_LSB + 1)) u_upb (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .wr_en   (reg_hit(wr, sel, mpr_pkg::MPR_SEL_UPB)),
    .wdata   (apb_req.pwdata),
    .value   (upb)
  );

  mpr_base_field #(.W(`MPR_FLASH_FLD_MSB - `MPR_FLD_LSB + 1)) u_fup (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .wr_en   (reg_hit(wr, sel, mpr_pkg::MPR_SEL_FUP)),
    .wdata   (apb_req.pwdata),
    .value   (fup)
  );

  // Read data registered in the setup cycle so it is stable in the access cycle
  always_comb begin
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (apb_req.psel && !apb_req.penable) begin
      pslverr_next = (sel == mpr_pkg::MPR_SEL_NONE);
    end else if (apb_req.psel) begin
      pslverr_next = pslverr_reg;
    end
    if (rd) begin
      unique case (sel)
        mpr_pkg::MPR_SEL_KPB:  prdata_next = kpb;
        mpr_pkg::MPR_SEL_UDB:  prdata_next = udb;
        mpr_pkg::MPR_SEL_UPB:  prdata_next = upb;
        mpr_pkg::MPR_SEL_DRS:  prdata_next = DATA_RAM_SIZE;
        mpr_pkg::MPR_SEL_FUP:  prdata_next = fup;
        mpr_pkg::MPR_SEL_PFS:  prdata_next = FLASH_SIZE;
        mpr_pkg::MPR_SEL_BFS:  prdata_next = `MPR_BOOT_SIZE;
        mpr_pkg::MPR_SEL_NONE: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg && apb_req.psel && apb_req.penable;

  // Decode view, updated from the edge after the write
  always_comb begin
    map.ram_kernel_program_base = kpb;
    map.ram_user_data_base      = udb;
    map.ram_user_program_base   = upb;
    map.flash_user_program_base = fup;
    map.user_ram_phys_start     = `MPR_USER_RAM_PHYS + udb;
    map.user_flash_phys_start   = `MPR_USER_FLASH_PHYS + fup;
  end

  // Software ordering constraints are not enforced in hardware

  property p_low_zero;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && (sel == mpr_pkg::MPR_SEL_UDB || sel == mpr_pkg::MPR_SEL_UPB)) |=> (prdata[10:0] == 11'h000);
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("RAM base low bits not zero");

  property p_fup_low_zero;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && sel == mpr_pkg::MPR_SEL_FUP) |=> (prdata[10:0] == 11'h000);
  endproperty
  a_fup_low_zero: assert property (p_fup_low_zero) else $error("Flash base low bits not zero");

  property p_hi_zero;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && (sel == mpr_pkg::MPR_SEL_UDB || sel == mpr_pkg::MPR_SEL_UPB)) |=> (prdata[31:16] == 16'h0000);
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("RAM base reserved bits not zero");

  property p_fup_hi_zero;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && sel == mpr_pkg::MPR_SEL_FUP) |=> (prdata[31:20] == 12'h000);
  endproperty
  a_fup_hi_zero: assert property (p_fup_hi_zero) else $error("Flash base reserved bits not zero");

  property p_udb_write;
    @(posedge sys_clk) disable iff (!nrst)
      (wr && sel == mpr_pkg::MPR_SEL_UDB) |=> (udb[15:11] == $past(apb_req.pwdata[15:11]));
  endproperty
  a_udb_write: assert property (p_udb_write) else $error("User data base not written");

  property p_upb_write;
    @(posedge sys_clk) disable iff (!nrst)
      (wr && sel == mpr_pkg::MPR_SEL_UPB) |=> (upb[15:11] == $past(apb_req.pwdata[15:11]));
  endproperty
  a_upb_write: assert property (p_upb_write) else $error("User program base not written");

  property p_fup_write;
    @(posedge sys_clk) disable iff (!nrst)
      (wr && sel == mpr_pkg::MPR_SEL_FUP) |=> (fup[19:11] == $past(apb_req.pwdata[19:11]));
  endproperty
  a_fup_write: assert property (p_fup_write) else $error("Flash user base not written");

  property p_hold;
    @(posedge sys_clk) disable iff (!nrst)
      !wr |=> $stable(udb) && $stable(upb) && $stable(fup);
  endproperty
  a_hold: assert property (p_hold) else $error("Base changed without write");

  property p_boot_read;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && sel == mpr_pkg::MPR_SEL_BFS) |=> (prdata == 32'h0000_3000);
  endproperty
  a_boot_read: assert property (p_boot_read) else $error("Boot size wrong");

  property p_ram_read;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && sel == mpr_pkg::MPR_SEL_DRS) |=> (prdata == DATA_RAM_SIZE);
  endproperty
  a_ram_read: assert property (p_ram_read) else $error("RAM size wrong");

  property p_flash_read;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && sel == mpr_pkg::MPR_SEL_PFS) |=> (prdata == FLASH_SIZE);
  endproperty
  a_flash_read: assert property (p_flash_read) else $error("Flash size wrong");

  property p_phys;
    @(posedge sys_clk) disable iff (!nrst)
      (wr && sel == mpr_pkg::MPR_SEL_UDB) |=> (map.user_ram_phys_start == 32'hBF00_0000 + udb);
  endproperty
  a_phys: assert property (p_phys) else $error("User RAM start wrong");

  property p_kpb_write;
    @(posedge sys_clk) disable iff (!nrst)
      reg_hit(wr, sel, mpr_pkg::MPR_SEL_KPB) |=> (kpb[15:11] == $past(apb_req.pwdata[15:11]));
  endproperty
  a_kpb_write: assert property (p_kpb_write) else $error("Kernel program base not written");

  property p_kpb_hold;
    @(posedge sys_clk) disable iff (!nrst)
      !reg_hit(wr, sel, mpr_pkg::MPR_SEL_KPB) |=> $stable(kpb);
  endproperty
  a_kpb_hold: assert property (p_kpb_hold) else $error("Kernel program base changed");

  property p_udb_only;
    @(posedge sys_clk) disable iff (!nrst)
      !reg_hit(wr, sel, mpr_pkg::MPR_SEL_UDB) |=> $stable(udb);
  endproperty
  a_udb_only: assert property (p_udb_only) else $error("User data base changed by other write");

  property p_kpb_read;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && sel == mpr_pkg::MPR_SEL_KPB) |=> (prdata == $past(kpb));
  endproperty
  a_kpb_read: assert property (p_kpb_read) else $error("Kernel program base read wrong");

  property p_udb_read;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && sel == mpr_pkg::MPR_SEL_UDB) |=> (prdata == $past(udb));
  endproperty
  a_udb_read: assert property (p_udb_read) else $error("User data base read wrong");

  property p_upb_read;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && sel == mpr_pkg::MPR_SEL_UPB) |=> (prdata == $past(upb));
  endproperty
  a_upb_read: assert property (p_upb_read) else $error("User program base read wrong");

  property p_fup_read;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && sel == mpr_pkg::MPR_SEL_FUP) |=> (prdata == $past(fup));
  endproperty
  a_fup_read: assert property (p_fup_read) else $error("Flash user base read wrong");

  property p_kpb_low_zero;
    @(posedge sys_clk) disable iff (!nrst)
      (rd && sel == mpr_pkg::MPR_SEL_KPB) |=> (prdata[10:0] == 11'h000);
  endproperty
  a_kpb_low_zero: assert property (p_kpb_low_zero) else $error("Kernel base low bits not zero");

  // Checked from the second low edge so an early reset race cannot trip it
  property p_reset_clear;
    @(posedge sys_clk)
      (!nrst ##1 !nrst) |-> (kpb == 32'h0000_0000 && udb == 32'h0000_0000 && upb == 32'h0000_0000 &&
                             fup == 32'h0000_0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Base field not cleared by reset");

  property p_kpb_map;
    @(posedge sys_clk) disable iff (!nrst)
      reg_hit(wr, sel, mpr_pkg::MPR_SEL_KPB) |=> (map.ram_kernel_program_base[15:11] == $past(apb_req.pwdata[15:11]));
  endproperty
  a_kpb_map: assert property (p_kpb_map) else $error("Decode view of kernel base late");

  property p_udb_map;
    @(posedge sys_clk) disable iff (!nrst)
      reg_hit(wr, sel, mpr_pkg::MPR_SEL_UDB) |=> (map.ram_user_data_base[15:11] == $past(apb_req.pwdata[15:11]));
  endproperty
  a_udb_map: assert property (p_udb_map) else $error("Decode view of user data base late");

  property p_upb_map;
    @(posedge sys_clk) disable iff (!nrst)
      reg_hit(wr, sel, mpr_pkg::MPR_SEL_UPB) |=> (map.ram_user_program_base[15:11] == $past(apb_req.pwdata[15:11]));
  endproperty
  a_upb_map: assert property (p_upb_map) else $error("Decode view of user program base late");

  property p_fup_map;
    @(posedge sys_clk) disable iff (!nrst)
      reg_hit(wr, sel, mpr_pkg::MPR_SEL_FUP) |=> (map.flash_user_program_base[19:11] == $past(apb_req.pwdata[19:11]));
  endproperty
  a_fup_map: assert property (p_fup_map) else $error("Decode view of flash base late");

  property p_fup_phys;
    @(posedge sys_clk) disable iff (!nrst)
      reg_hit(wr, sel, mpr_pkg::MPR_SEL_FUP) |=>
        (map.user_flash_phys_start == `MPR_USER_FLASH_PHYS + {12'h000, $past(apb_req.pwdata[19:11]), 11'h000});
  endproperty
  a_fup_phys: assert property (p_fup_phys) else $error("User flash start wrong");

  c_udb_wr: cover property (@(posedge sys_clk) disable iff (!nrst) wr && sel == mpr_pkg::MPR_SEL_UDB);
  c_fup_wr: cover property (@(posedge sys_clk) disable iff (!nrst) wr && sel == mpr_pkg::MPR_SEL_FUP);
  c_err:    cover property (@(posedge sys_clk) disable iff (!nrst) pslverr);
  c_upb_wr: cover property (@(posedge sys_clk) disable iff (!nrst) wr && sel == mpr_pkg::MPR_SEL_UPB);
  c_sz_rd:  cover property (@(posedge sys_clk) disable iff (!nrst) rd && sel == mpr_pkg::MPR_SEL_PFS);
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench of the partition register bank
`timescale 1ns/100ps
`default_nettype none
`include "mpr_defs.svh"
module tb_top;
  logic                  sys_clk;
  logic                  nrst;
  mpr_pkg::mpr_apb_req_t req;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  mpr_pkg::mpr_map_t     map;
  int                    err_count;
  int                    check_count;
  logic [31:0]           rd;
  logic                  er;

  mpr_regs uut (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .apb_req (req),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .map     (map)
  );

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Setup cycle, then access until pready is seen high at a rising edge; answer taken at that edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rdat, output logic err);
    logic got;
    got  = 1'b0;
    rdat = 32'h0000_0000;
    err  = 1'b0;
    @(posedge sys_clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge sys_clk);
    req.penable <= 1'b1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) begin
        rdat = prdata;
        err  = pslverr;
        got  = 1'b1;
      end
    end
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    if (!got) begin
      err_count++;
      $display("mismatch at %0t: no pready", $time);
      summarize;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
    check({31'h0, e}, 32'h0000_0000);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0000_0000, r, e);
    check(r, exp);
    check({31'h0, e}, 32'h0000_0000);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    err_count   = 0;
    check_count = 0;
    nrst        = 1'b0;
    req         = '0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    rdchk(`MPR_OFS_USER_DATA, 32'h0000_0000);
    rdchk(`MPR_OFS_USER_PROG, 32'h0000_0000);
    rdchk(`MPR_OFS_FLASH_USER_PROG, 32'h0000_0000);
    rdchk(`MPR_OFS_DATA_RAM_SIZE, 32'h0000_8000);
    rdchk(`MPR_OFS_FLASH_SIZE, 32'h0008_0000);
    rdchk(`MPR_OFS_BOOT_SIZE, 32'h0000_3000);
    // Ascending bases with the read-only low bits written as ones
    wr(`MPR_OFS_KERNEL_PROG, 32'h0000_0FFF);
    wr(`MPR_OFS_USER_DATA, 32'h0000_1FFF);
    wr(`MPR_OFS_USER_PROG, 32'h0000_FFFF);
    wr(`MPR_OFS_FLASH_USER_PROG, 32'h0007_B7FF);
    rdchk(`MPR_OFS_KERNEL_PROG, 32'h0000_0800);
    rdchk(`MPR_OFS_USER_DATA, 32'h0000_1800);
    rdchk(`MPR_OFS_USER_PROG, 32'h0000_F800);
    rdchk(`MPR_OFS_FLASH_USER_PROG, 32'h0007_B000);
    check(map.ram_kernel_program_base, 32'h0000_0800);
    check(map.ram_user_data_base, 32'h0000_1800);
    check(map.ram_user_program_base, 32'h0000_F800);
    check(map.flash_user_program_base, 32'h0007_B000);
    check(map.user_ram_phys_start, 32'hBF00_1800);
    check(map.user_flash_phys_start, 32'hBD07_B000);
    wr(`MPR_OFS_FLASH_USER_PROG, 32'h000F_FFFF);
    rdchk(`MPR_OFS_FLASH_USER_PROG, 32'h000F_F800);
    // Constant sizes ignore writes
    wr(`MPR_OFS_DATA_RAM_SIZE, 32'h0000_0000);
    wr(`MPR_OFS_FLASH_SIZE, 32'h0000_0000);
    wr(`MPR_OFS_BOOT_SIZE, 32'h0000_0000);
    rdchk(`MPR_OFS_DATA_RAM_SIZE, 32'h0000_8000);
    rdchk(`MPR_OFS_FLASH_SIZE, 32'h0008_0000);
    rdchk(`MPR_OFS_BOOT_SIZE, 32'h0000_3000);
    // Unmapped offset answers with an error and reads zero
    xfer(1'b1, 12'h01C, 32'h0000_FFFF, rd, er);
    check({31'h0, er}, 32'h0000_0001);
    xfer(1'b0, 12'h01C, 32'h0000_0000, rd, er);
    check(rd, 32'h0000_0000);
    check({31'h0, er}, 32'h0000_0001);
    rdchk(`MPR_OFS_USER_DATA, 32'h0000_1800);
    // Reset in mid-run removes every partition
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    rdchk(`MPR_OFS_KERNEL_PROG, 32'h0000_0000);
    rdchk(`MPR_OFS_USER_DATA, 32'h0000_0000);
    rdchk(`MPR_OFS_USER_PROG, 32'h0000_0000);
    rdchk(`MPR_OFS_FLASH_USER_PROG, 32'h0000_0000);
    check(map.user_ram_phys_start, 32'hBF00_0000);
    check(map.user_flash_phys_start, 32'hBD00_0000);
    summarize;
  end
endmodule
`default_nettype wire
